// file: logic/clock_source_control_regs.v
// Purpose: register block of an on-chip clock generation unit: source and bus
//          divider selection, reference divider, reference enables with stop
//          retention, oscillator controls and trim.
// Assumes: all three source clocks arrive as enable strobes (one pulse per
//          source edge) synchronous to clk, so the bus clock is built as a
//          glitch-free toggle in the clk domain.
// Notes:   factory trim and debug level are pins, sampled after reset release.
//          trim capture waits for the debug synchroniser, so writes in the
//          first three cycles after reset are dropped.
//          stop and debug levels pass two flip-flops before use.
//          a source or divider change waits for the end of a bus clock
//          period, so it may take one full old period to show.
//          reserved divider codes with the high range pass on unchanged.
//          status mode lags the switched source by two cycles.
//
// Operation
// R1 - source select 00 loop, 01 internal ref, 10 external ref feeds bus divider
// R2 - reserved source code 11 acts exactly like 00, loop output
// R3 - software keeps divided external reference inside 31.25 to 39.0625 kHz
// R4 - reference divide 2^code low range, 32 times that high range, 6-7 reserved
// R5 - internal reference select bit 2: 1 internal, 0 external loop reference
// R6 - internal reference enable bit 1 turns internal reference output on
// R7 - in stop internal reference runs only if keep bit and enable set before stop
// R8 - bus divider 00..11 divides by 1,2,4,8; resets to code 01
// R9 - range bit 5 requests high oscillator range when 1
// R10 - gain bit 4 selects high gain when 1, low power when 0
// R11 - low power bit disables loop in bypass modes unless debug active
// R12 - external select bit 2 requests crystal when 1, direct clock when 0
// R13 - external enable bit 1 turns external reference output on
// R14 - in stop external source stays on only if keep bit and enable set before stop
// R15 - eight-bit trim sets internal reference period, larger value longer period
// R16 - trim loads factory value at reset, 0x80 when debug active
// R17 - fine trim bit gives smallest step, set lengthens period
// R18 - clock mode status follows source select only after synchronisation
// R19 - source or divider changes cause no shortened bus clock pulses
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "clock_source_map.vh"

module clock_source_control_regs
(
    input  wire                 clk,
    input  wire                 rst_n,
    input  wire [`ADDR_W-1:0]   addr,
    input  wire [7:0]           wdata,
    input  wire                 wr,
    input  wire                 rd,
    output reg  [7:0]           rdata,
    input  wire                 loop_tick,
    input  wire                 internal_tick,
    input  wire                 external_tick,
    input  wire                 stop_mode,
    input  wire                 background_debug_mode,
    input  wire [7:0]           factory_trim,
    input  wire                 factory_fine_trim,
    output reg                  bus_clock,
    output reg                  internal_ref_clock_out,
    output reg                  external_ref_clock_out,
    output reg                  oscillator_output,
    output reg                  oscillator_high_range,
    output reg                  oscillator_high_gain,
    output reg                  loop_enable,
    output reg                  loop_uses_internal,
    output reg  [2:0]           reference_divider,
    output reg                  reference_high_range,
    output reg  [7:0]           trim_value,
    output reg                  fine_trim_bit
);

    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    reg  [7:0] clock_control_one;
    reg  [7:0] clock_control_two;
    reg  [7:0] reference_trim;
    reg        fine_trim;
    reg        trim_loaded;
    reg  [1:0] load_wait;
    reg        dbg_s1;
    reg        dbg_s2;
    reg        stop_s1;
    reg        stop_s2;
    reg        stop_prev;
    reg        iref_kept;
    reg        eref_kept;
    reg  [1:0] active_src;
    reg  [1:0] active_div;
    reg  [1:0] mode_s1;
    reg  [1:0] clock_mode_status;
    reg  [2:0] div_count;
    reg        next_bus_clock;

    wire [1:0] clock_source_select = clock_control_one[`CSEL_HI:`CSEL_LO];
    wire [1:0] bus_divider         = clock_control_two[`BUS_DIVIDER_HI:`BUS_DIVIDER_LO];
    wire       low_power_bypass    = clock_control_two[`LOWPWR_BIT];
    wire       stop_entry          = stop_s2 & ~stop_prev;

    // kept enables, already valid at the entry edge itself, so the
    // outputs never show a stale value left from an earlier stop
    wire       iref_keep_now = stop_entry ? (clock_control_one[`IREF_EN_BIT] &
                               clock_control_one[`IREF_STOP_BIT]) : iref_kept; // R7
    wire       eref_keep_now = stop_entry ? (clock_control_two[`EREF_EN_BIT] &
                               clock_control_two[`EREF_STOP_BIT]) : eref_kept; // R14

    // reserved source code folds to the loop
    wire [1:0] eff_src = (clock_source_select == `SRC_RESERVED) ?
                         `SRC_LOOP : clock_source_select; // R2

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dbg_s1  <= 1'b0;
            dbg_s2  <= 1'b0;
            stop_s1 <= 1'b0;
            stop_s2 <= 1'b0;
        end
        else
        begin
            dbg_s1  <= background_debug_mode;
            dbg_s2  <= dbg_s1;
            stop_s1 <= stop_mode;
            stop_s2 <= stop_s1;
        end
    end

    // ------------------------------------------------------------------
    // software registers and trim capture after reset
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clock_control_one <= `CTRL1_RESET;
            clock_control_two <= `CTRL2_RESET; // R8
            reference_trim    <= `TRIM_DEBUG;
            fine_trim         <= `FINE_TRIM_BIT_DEBUG;
            trim_loaded       <= 1'b0;
            load_wait         <= 2'h0;
        end
        else if (!trim_loaded)
        begin
            // catch trim only once the debug level has crossed both stages;
            // earlier, the second stage still holds its reset value
            load_wait <= load_wait + 2'h1;
            if (load_wait == `TRIM_LOAD_WAIT)
            begin
                trim_loaded    <= 1'b1;
                reference_trim <= dbg_s2 ? `TRIM_DEBUG : factory_trim; // R16
                fine_trim      <= dbg_s2 ? `FINE_TRIM_BIT_DEBUG : factory_fine_trim;
            end
        end
        else if (wr)
        begin
            // of the status index only the fine trim bit is writable
            case (addr)
                `OFF_CONTROL_ONE: clock_control_one <= wdata;
                `OFF_CONTROL_TWO: clock_control_two <= wdata;
                `OFF_TRIM:        reference_trim    <= wdata; // R15
                `OFF_STATUS:      fine_trim         <= wdata[`FINE_TRIM_BIT_BIT]; // R17
                default:          fine_trim         <= fine_trim;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read port, data valid the cycle after the strobe
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= `ZERO8;
        else if (rd)
        begin
            // unmapped indices and idle cycles read as zero
            case (addr)
                `OFF_CONTROL_ONE: rdata <= clock_control_one;
                `OFF_CONTROL_TWO: rdata <= clock_control_two;
                `OFF_TRIM:        rdata <= reference_trim;
                `OFF_STATUS:      rdata <= {4'h0, clock_mode_status, 1'b0, fine_trim}; // R18
                default:          rdata <= `ZERO8;
            endcase
        end
        else
            rdata <= `ZERO8;
    end

    // ------------------------------------------------------------------
    // stop retention: latch enables as they stood on stop entry
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stop_prev <= 1'b0;
            iref_kept <= 1'b0;
            eref_kept <= 1'b0;
        end
        else
        begin
            stop_prev <= stop_s2;
            // keep only what was both enabled and marked to survive stop
            if (stop_entry)
            begin
                iref_kept <= clock_control_one[`IREF_EN_BIT] &
                             clock_control_one[`IREF_STOP_BIT]; // R7
                eref_kept <= clock_control_two[`EREF_EN_BIT] &
                             clock_control_two[`EREF_STOP_BIT]; // R14
            end
        end
    end

    // ------------------------------------------------------------------
    // bus clock: source and divider only change at a bus clock high phase end or in a low phase before its first tick
    // ------------------------------------------------------------------
    // selected source tick; reserved code is already folded to the loop
    reg src_tick;
    always @*
    begin
        case (active_src)
            `SRC_INTERNAL: src_tick = internal_tick; // R1
            `SRC_EXTERNAL: src_tick = external_tick; // R1
            default:       src_tick = loop_tick;     // R1
        endcase
    end

    // ticks per half period minus one: 0, 1, 3, 7 for divide by 1, 2, 4, 8;
    // worked at four bits so that code 11 does not wrap
    wire [3:0] div_span  = (4'h1 << active_div) - 4'h1;
    wire [2:0] div_limit = div_span[2:0];
    wire       half_done = src_tick && (div_count >= div_limit); // R8

    // hold the level while stopped, the bus clock is frozen in stop
    always @*
    begin
        next_bus_clock = bus_clock;
        if (half_done && !stop_s2)
            next_bus_clock = ~bus_clock;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_clock  <= 1'b0;
            div_count  <= 3'h0;
            active_src <= `SRC_LOOP;
            active_div <= 2'h1;
        end
        else
        begin
            bus_clock <= next_bus_clock; // R8
            // counter restarts at each toggle so every half period is whole
            if (half_done)
                div_count <= 3'h0;
            else if (src_tick)
                div_count <= div_count + 3'h1;
            // switch only at a high phase end or in a low phase before its first tick, so no pulse is cut
            if ((half_done && bus_clock) || (!bus_clock && div_count == 3'h0
                && !src_tick))
            begin
                active_src <= eff_src; // R19
                active_div <= bus_divider; // R19
            end
        end
    end

    // ------------------------------------------------------------------
    // status: mode follows the switched source through two stages
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_s1           <= `SRC_LOOP;
            clock_mode_status <= `SRC_LOOP;
        end
        else
        begin
            // two stages, so software never reads a half-switched mode
            mode_s1           <= active_src;
            clock_mode_status <= mode_s1; // R18
        end
    end

    // ------------------------------------------------------------------
    // reference, oscillator and loop control outputs
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            internal_ref_clock_out <= 1'b0;
            external_ref_clock_out <= 1'b0;
            oscillator_output      <= 1'b0;
            oscillator_high_range  <= 1'b0;
            oscillator_high_gain   <= 1'b0;
            loop_enable            <= 1'b1;
            loop_uses_internal     <= 1'b1;
            reference_divider      <= 3'h0;
            reference_high_range   <= 1'b0;
            trim_value             <= `TRIM_DEBUG;
            fine_trim_bit          <= `FINE_TRIM_BIT_DEBUG;
        end
        else
        begin
            // in stop the reference enables show what was kept on entry
            internal_ref_clock_out <= stop_s2 ? iref_keep_now :
                                      clock_control_one[`IREF_EN_BIT]; // R6
            external_ref_clock_out <= stop_s2 ? eref_keep_now :
                                      clock_control_two[`EREF_EN_BIT]; // R13
            // oscillator requested only when crystal chosen and a reason to run
            oscillator_output      <= clock_control_two[`EREF_SEL_BIT] &
                                      (stop_s2 ? eref_keep_now :
                                       (clock_control_two[`EREF_EN_BIT] |
                                        eff_src == `SRC_EXTERNAL |
                                        ~clock_control_one[`IREF_SEL_BIT])); // R12
            oscillator_high_range  <= clock_control_two[`RANGE_BIT]; // R9
            oscillator_high_gain   <= clock_control_two[`GAIN_BIT]; // R10
            // loop runs unless stopped, or bypassed in low power without debug
            loop_enable            <= ~stop_s2 & ~(eff_src != `SRC_LOOP &&
                                      low_power_bypass && !dbg_s2); // R11
            loop_uses_internal     <= clock_control_one[`IREF_SEL_BIT]; // R5
            // divider code passed on raw, the loop decodes it with the range
            reference_divider      <= clock_control_one[`REFERENCE_DIVIDER_HI:`REFERENCE_DIVIDER_LO]; // R4
            reference_high_range   <= clock_control_two[`RANGE_BIT]; // R4
            trim_value             <= reference_trim; // R15
            fine_trim_bit          <= fine_trim; // R17
        end
    end

endmodule

// file: logic/clock_source_map.vh
// Purpose: register offsets, field positions and reset values of the clock source control block
// Assumes: byte registers on a plain strobe port
// Notes:   definitions only
`ifndef CLOCK_SOURCE_MAP_VH
`define CLOCK_SOURCE_MAP_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADDR_W            3
`define OFF_CONTROL_ONE   3'h0
`define OFF_CONTROL_TWO   3'h1
`define OFF_TRIM          3'h2
`define OFF_STATUS        3'h3

// ----------------------------------------------------------------------
// fields of clock_control_one
// ----------------------------------------------------------------------
`define CSEL_HI           7
`define CSEL_LO           6
`define REFERENCE_DIVIDER_HI           5
`define REFERENCE_DIVIDER_LO           3
`define IREF_SEL_BIT      2
`define IREF_EN_BIT       1
`define IREF_STOP_BIT     0

// ----------------------------------------------------------------------
// fields of clock_control_two
// ----------------------------------------------------------------------
`define BUS_DIVIDER_HI           7
`define BUS_DIVIDER_LO           6
`define RANGE_BIT         5
`define GAIN_BIT          4
`define LOWPWR_BIT        3
`define EREF_SEL_BIT      2
`define EREF_EN_BIT       1
`define EREF_STOP_BIT     0

// ----------------------------------------------------------------------
// fields of the status register
// ----------------------------------------------------------------------
`define MODE_ST_HI        3
`define MODE_ST_LO        2
`define FINE_TRIM_BIT_BIT         0

// ----------------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------------
`define SRC_LOOP          2'h0
`define SRC_INTERNAL      2'h1
`define SRC_EXTERNAL      2'h2
`define SRC_RESERVED      2'h3
`define CTRL1_RESET       8'h04
`define CTRL2_RESET       8'h40
`define TRIM_DEBUG        8'h80
`define FINE_TRIM_BIT_DEBUG       1'h0
`define TRIM_LOAD_WAIT    2'h2
`define HIGH_RANGE_SHIFT  4'h5
`define REFERENCE_DIVIDER_MAX_HIGH     3'h5
`define BUS_DIVIDER_MAX          3'h7
`define ZERO8             8'h00

`endif

// file: verif/clock_source_control_regs_asserts.sv
// Purpose: port-level assertions of the clock source control block
// Assumes: the bench makes no request in the first four edges after reset
// Notes:   bound to the design top at the foot of this file
`timescale 1ns/1ps
`include "clock_source_map.vh"

module clock_source_control_regs_asserts
(
    input wire               clk,
    input wire               rst_n,
    input wire [`ADDR_W-1:0] addr,
    input wire [7:0]         wdata,
    input wire               wr,
    input wire               rd,
    input wire [7:0]         rdata,
    input wire               stop_mode,
    input wire               internal_ref_clock_out,
    input wire               external_ref_clock_out,
    input wire               oscillator_high_range,
    input wire               oscillator_high_gain,
    input wire [2:0]         reference_divider
);
    logic [2:0] settle;
    wire        ready = (settle == 3'h4);

    // count edges since reset, the design drops earlier writes
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            settle <= 3'h0;
        else if (!ready)
            settle <= settle + 3'h1;

    // ------------------------------------------------------------
    // register port relations
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wr_one;
        ready && wr && addr == `OFF_CONTROL_ONE;
    endsequence
    sequence wr_two;
        ready && wr && addr == `OFF_CONTROL_TWO;
    endsequence

    a_read_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data left standing");
    a_read_back: assert property (wr_one ##2 (rd && addr == `OFF_CONTROL_ONE)
        |=> rdata == $past(wdata, 3)) else $error("control_one read back");
    a_refdiv_follows: assert property (
        wr_one |-> ##2 reference_divider == $past(wdata[5:3], 2)) else $error("ref divider");
    a_range_follows: assert property (
        wr_two |-> ##2 oscillator_high_range == $past(wdata[5], 2)) else $error("range");
    a_gain_follows: assert property (
        wr_two |-> ##2 oscillator_high_gain == $past(wdata[4], 2)) else $error("gain");
    a_iref_enable: assert property (
        (!stop_mode)[*4] ##0 wr_one |-> ##2 internal_ref_clock_out == $past(wdata[1], 2))
        else $error("internal ref enable");
    a_eref_enable: assert property (
        (!stop_mode)[*4] ##0 wr_two |-> ##2 external_ref_clock_out == $past(wdata[1], 2))
        else $error("external ref enable");
    a_stop_iref: assert property ((stop_mode)[*5] |-> !$rose(internal_ref_clock_out))
        else $error("internal ref woke in stop");
    a_stop_eref: assert property ((stop_mode)[*5] |-> !$rose(external_ref_clock_out))
        else $error("external ref woke in stop");
endmodule

bind clock_source_control_regs clock_source_control_regs_asserts i_clock_source_control_regs_asserts
    (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .stop_mode, .internal_ref_clock_out,
     .external_ref_clock_out, .oscillator_high_range, .oscillator_high_gain, .reference_divider);

// file: verif/clock_source_control_regs_tb.sv
// Purpose: self-checking bench of the clock source control block
// Assumes: loop ticks every cycle, internal ticks every second cycle
// Notes:   the oscillator model makes the external ticks
`timescale 1ns/1ps
`include "clock_source_map.vh"

module clock_source_control_regs_tb;
    logic               clk, rst_n, wr, rd, stop_mode, loop_tick, internal_tick;
    logic               external_tick, background_debug_mode, factory_fine_trim;
    logic               bus_clock, internal_ref_clock_out, external_ref_clock_out;
    logic               oscillator_output, oscillator_high_range, oscillator_high_gain;
    logic               loop_enable, loop_uses_internal, reference_high_range, fine_trim_bit;
    logic [`ADDR_W-1:0] addr;
    logic [7:0]         wdata, rdata, factory_trim, trim_value, got;
    logic [2:0]         reference_divider;
    int                 err_total, checks_done;

    clock_source_control_regs i_clock_source_control_regs (.clk, .rst_n, .addr, .wdata,
        .wr, .rd, .rdata, .loop_tick, .internal_tick, .external_tick, .stop_mode,
        .background_debug_mode, .factory_trim, .factory_fine_trim, .bus_clock,
        .internal_ref_clock_out, .external_ref_clock_out, .oscillator_output,
        .oscillator_high_range, .oscillator_high_gain, .loop_enable, .loop_uses_internal,
        .reference_divider, .reference_high_range, .trim_value, .fine_trim_bit);
    crystal_osc_model i_crystal_osc_model (.clk, .rst_n, .oscillator_output,
        .oscillator_high_range, .oscillator_high_gain, .external_tick);

    // clock and the internal source ticks
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) internal_tick <= ~internal_tick;

    // ------------------------------------------------------------
    // bus cycles and comparison
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [`ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic do_reset(input logic dbg);
        rst_n <= 1'b0;
        background_debug_mode <= dbg;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        idle(4);
    endtask
    task automatic count_toggles(output logic [7:0] n);
        logic last;
        n = 8'h00;
        last = bus_clock;
        repeat (32)
        begin
            idle(1);
            if (bus_clock !== last)
                n = n + 8'h01;
            last = bus_clock;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_regs;
        rd_reg(`OFF_CONTROL_ONE, got);
        chk("control_one", `CTRL1_RESET, got);
        rd_reg(`OFF_CONTROL_TWO, got);
        chk("control_two", `CTRL2_RESET, got);
        rd_reg(`OFF_TRIM, got);
        chk("debug trim", `TRIM_DEBUG, got);
        wr_reg(`OFF_CONTROL_TWO, 8'h30);
        wr_reg(`OFF_CONTROL_ONE, 8'h28);
        rd_reg(`OFF_CONTROL_ONE, got);
        chk("readback", 8'h28, got);
        chk("ref divider", 8'h05, {5'h0, reference_divider});
        chk("loop ref", 8'h00, {7'h0, loop_uses_internal});
        chk("range", 8'h03, {6'h0, oscillator_high_range, reference_high_range});
        chk("gain", 8'h01, {7'h0, oscillator_high_gain});
        wr_reg(`OFF_TRIM, 8'h3C);
        wr_reg(`OFF_STATUS, 8'h01);
        wr_reg(3'h5, 8'hFF);
        idle(2);
        chk("trim", 8'h3C, trim_value);
        chk("fine trim", 8'h01, {7'h0, fine_trim_bit});
        rd_reg(3'h5, got);
        chk("unmapped", 8'h00, got);
    endtask
    task automatic test_factory;
        factory_trim <= 8'h5A;
        factory_fine_trim <= 1'b1;
        do_reset(1'b0);
        chk("factory trim", 8'h5A, trim_value);
        rd_reg(`OFF_STATUS, got);
        chk("status", 8'h01, got);
    endtask
    task automatic test_sources;
        logic [7:0] exp;
        for (int c = 0; c < 4; c++)
            for (int d = 0; d < 4; d++)
            begin
                wr_reg(`OFF_CONTROL_TWO, {d[1:0], 6'h16});
                wr_reg(`OFF_CONTROL_ONE, {c[1:0], 6'h06});
                idle(80);
                count_toggles(got);
                exp = (c == 1) ? 8'h10 : (c == 2) ? 8'h08 : 8'h20;
                chk("bus toggles", exp >> d, got);
                rd_reg(`OFF_STATUS, got);
                chk("mode", {4'h0, (c == 3) ? 2'h0 : c[1:0], 2'h1}, got);
            end
    endtask
    task automatic test_low_power;
        wr_reg(`OFF_CONTROL_TWO, 8'h5E);
        wr_reg(`OFF_CONTROL_ONE, 8'h46);
        idle(20);
        chk("loop off", 8'h00, {7'h0, loop_enable});
        background_debug_mode <= 1'b1;
        idle(20);
        chk("loop debug", 8'h01, {7'h0, loop_enable});
        background_debug_mode <= 1'b0;
        wr_reg(`OFF_CONTROL_TWO, 8'h56);
        idle(20);
        chk("loop kept", 8'h01, {7'h0, loop_enable});
    endtask
    task automatic test_stop;
        wr_reg(`OFF_CONTROL_ONE, 8'h47);
        idle(4);
        chk("osc request", 8'h01, {7'h0, oscillator_output});
        stop_mode <= 1'b1;
        idle(8);
        chk("stop refs", 8'h02, {6'h0, internal_ref_clock_out, external_ref_clock_out});
        chk("stop osc", 8'h00, {7'h0, oscillator_output});
        count_toggles(got);
        chk("stop bus", 8'h00, got);
        stop_mode <= 1'b0;
        wr_reg(`OFF_CONTROL_TWO, 8'h52);
        idle(8);
        chk("run refs", 8'h03, {6'h0, internal_ref_clock_out, external_ref_clock_out});
        chk("direct osc", 8'h00, {7'h0, oscillator_output});
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {err_total, checks_done} = '0;
        {rst_n, wr, rd, stop_mode, internal_tick, factory_fine_trim} = '0;
        {loop_tick, background_debug_mode} = 2'h3;
        addr = '0;
        wdata = 8'h00;
        factory_trim = 8'hC3;
        do_reset(1'b1);
        test_regs;
        test_factory;
        test_sources;
        test_low_power;
        test_stop;
        complete_run;
    end

    // hang guard
    initial
    begin
        repeat (100000) @(posedge clk);
        err_total++;
        complete_run;
    end
endmodule

// file: verif/crystal_osc_model.sv
// Purpose: behavioural crystal oscillator at the far side of the block
// Assumes: one tick per oscillator edge, in the clk domain
// Notes:   high gain starts sooner; high range ticks every 2 cycles, low every 4
`timescale 1ns/1ps

module crystal_osc_model
#(
    parameter int START_HIGH_GAIN = 8,
    parameter int START_LOW_POWER = 16
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic oscillator_output,
    input  wire logic oscillator_high_range,
    input  wire logic oscillator_high_gain,
    output logic      external_tick
);
    int         warm;
    logic [1:0] phase;

    // start-up count, then ticks while requested; silent when not requested
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n || !oscillator_output)
        begin
            warm          <= 0;
            phase         <= 2'h0;
            external_tick <= 1'b0;
        end
        else if (warm < (oscillator_high_gain ? START_HIGH_GAIN : START_LOW_POWER))
            warm <= warm + 1;
        else
        begin
            phase         <= phase + 2'h1;
            external_tick <= oscillator_high_range ? phase[0] : (phase == 2'h3);
        end
    end
endmodule
